//--- dv/acc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module acc_host_model (
  input wire logic clock,
  input wire logic stall,
  input wire logic rd_req_ready,
  input wire logic rd_data_valid,
  input wire logic [7:0] rd_data,
  output logic rd_req_valid,
  output logic rd_req_first,
  output logic [6:0] rd_req_addr,
  output logic bus_stop,
  output logic rd_data_ready
);
  logic [7:0] got[$];
  logic hung = 1'h0;
  initial begin
    rd_req_valid = 1'h0;
    rd_req_first = 1'h0;
    rd_req_addr = 7'h55;
    bus_stop = 1'h0;
  end
  // slow answers: the bench raises stall
  assign rd_data_ready = !stall;
  always @(posedge clock)
    if (rd_data_valid && rd_data_ready)
      got.push_back(rd_data);
  // low bytes are asked for right after their high and also on their own
  task automatic req(input logic f, input logic [6:0] a);
    int n;
    n = 0;
    rd_req_valid = 1'h1;
    rd_req_first = f;
    rd_req_addr = a;
    while (!rd_req_ready && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    hung = hung | (n == 100);
    @(posedge clock);
    #1;
  endtask
  // inverted so a stale address can never pass for a request
  task automatic drop_req();
    rd_req_valid = 1'h0;
    rd_req_first = ~rd_req_first;
    rd_req_addr = ~rd_req_addr;
  endtask
  task automatic stop();
    bus_stop = 1'h1;
    @(posedge clock);
    #1;
    bus_stop = 1'h0;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import acc_pkg::*;
  logic clock = 1'h0, rst_b = 1'h0, smp_valid = 1'h0, fast_read = 1'h0;
  logic drdy_irq_en = 1'h1, hold = 1'h0, jam = 1'h0, stall;
  logic [2:0] smp_axis_en = 3'h0, axis_active = 3'h7;
  logic [11:0] smp_x = 12'h000, smp_y = 12'h000, smp_z = 12'h000, v;
  logic [1:0] operating_mode = 2'h0;
  logic [4:0] func_irq = 5'h00;
  logic [3:0] func_src_rd = 4'h0;
  logic rd_req_ready, rd_data_valid, rd_req_valid, rd_req_first;
  logic bus_stop, rd_data_ready, sample_ready_irq_flag;
  logic [6:0] rd_req_addr;
  logic [7:0] rd_data, exq[$];
  int err_count = 0, tests_run = 0, seed = 25;
  logic [11:0] m_smp[3] = '{default: 12'h000};
  logic [2:0] m_rdy = 3'h0, m_ow = 3'h0;
  logic m_rc = 1'h0, m_oc = 1'h0;
  logic [7:0] m_src = 8'h00;
  always #2 clock = ~clock;
  always @(posedge clock)
    jam <= $random(seed) % 3 == 0;
  assign stall = hold | jam;
  acc_sample_regs acc_sample_regs_inst (.clock, .rst_b, .smp_valid,
    .smp_axis_en, .smp_x, .smp_y, .smp_z, .axis_active, .fast_read,
    .operating_mode, .func_irq, .func_src_rd, .drdy_irq_en, .rd_req_valid,
    .rd_req_ready, .rd_req_first, .rd_req_addr, .bus_stop, .rd_data_valid,
    .rd_data_ready, .rd_data, .sample_ready_irq_flag);
  acc_host_model acc_host_model_inst (.clock, .stall, .rd_req_ready,
    .rd_data_valid, .rd_data, .rd_req_valid, .rd_req_first, .rd_req_addr,
    .bus_stop, .rd_data_ready);
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] reg_val(input logic [6:0] a,
                                         input logic paired);
    case (a)
      7'h00: return {m_oc, m_ow, m_rc, m_rdy};
      7'h01, 7'h03, 7'h05: return m_smp[a >> 1][11:4];
      7'h02, 7'h04, 7'h06: return paired ? {m_smp[(a - 1) >> 1][3:0], 4'h0} : 8'h00;
      7'h0b: return {6'h00, operating_mode};
      7'h0c: return m_src;
      default: return 8'h00;
    endcase
  endfunction
  task automatic hi_read(input int i);
    m_rdy[i] = 1'h0;
    m_ow[i] = 1'h0;
    if ((m_rdy & axis_active) == 3'h0) begin
      m_rc = 1'h0;
      m_oc = 1'h0;
      m_src[0] = 1'h0;
    end
  endtask
  // valid drops for a cycle so it is never driven twice in one step
  task automatic put(input logic [2:0] en);
    smp_valid = 1'h1;
    smp_axis_en = en;
    smp_x = 12'($random(seed));
    smp_y = 12'($random(seed));
    smp_z = 12'($random(seed));
    for (int i = 0; i < 3; i++)
      if (en[i]) begin
        m_oc = m_oc | m_rdy[i];
        m_ow[i] = m_ow[i] | m_rdy[i];
        m_rdy[i] = 1'h1;
        m_rc = m_rc | axis_active[i];
        m_smp[i] = i == 0 ? smp_x : i == 1 ? smp_y : smp_z;
      end
    m_src[0] = m_src[0] | m_rc | m_oc;
    @(posedge clock);
    #1;
    smp_valid = 1'h0;
    @(posedge clock);
    #1;
  endtask
  task automatic collect();
    int n;
    n = 0;
    while (acc_host_model_inst.got.size() < exq.size() && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 200 || acc_host_model_inst.hung) begin
      err_count++;
      tally_and_finish();
    end
    while (exq.size() > 0)
      chk8("read byte", exq.pop_front(), acc_host_model_inst.got.pop_front());
  endtask
  task automatic rd_seq(input logic [6:0] a, input int n);
    logic [6:0] p;
    p = a;
    for (int k = 0; k < n; k++) begin
      exq.push_back(reg_val(p, k > 0));
      acc_host_model_inst.req(k == 0, p);
      if (p == 7'h0b)
        m_src[7] = 1'h0;
      if (p inside {7'h01, 7'h03, 7'h05})
        hi_read(p >> 1);
      if (fast_read)
        p = p == 7'h05 ? 7'h00 : p + (p == 7'h00 ? 7'h01 : 7'h02);
      else
        p = p == 7'h06 ? 7'h00 : p + 7'h01;
    end
    acc_host_model_inst.drop_req();
    collect();
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'h1;
    rd_seq(7'h00, 7);
    func_irq = 5'h1f;
    @(posedge clock);
    #1;
    m_src = 8'hbc;
    rd_seq(7'h0c, 1);
    func_src_rd = 4'hf;
    @(posedge clock);
    #1;
    func_src_rd = 4'h0;
    m_src = 8'h80;
    rd_seq(7'h0c, 1);
    for (int m = 0; m < 3; m++) begin
      operating_mode = 2'(m);
      rd_seq(7'h0b, 1);
    end
    rd_seq(7'h0c, 1);
    axis_active = 3'h1;
    put(3'h6);
    rd_seq(7'h00, 7);
    axis_active = 3'h7;
    put(3'h7);
    v = m_smp[0];
    rd_seq(7'h01, 1);
    put(3'h1);
    exq.push_back({v[3:0], 4'h0});
    acc_host_model_inst.req(1'h0, 7'h00);
    acc_host_model_inst.drop_req();
    collect();
    acc_host_model_inst.stop();
    exq.push_back(reg_val(7'h00, 1'h0));
    acc_host_model_inst.req(1'h0, 7'h00);
    acc_host_model_inst.drop_req();
    collect();
    rd_seq(7'h02, 1);
    rd_seq(7'h07, 1);
    hold = 1'h1;
    exq.push_back(reg_val(7'h00, 1'h0));
    exq.push_back(reg_val(7'h0b, 1'h0));
    exq.push_back(reg_val(7'h0c, 1'h0));
    acc_host_model_inst.req(1'h1, 7'h00);
    acc_host_model_inst.req(1'h1, 7'h0b);
    acc_host_model_inst.drop_req();
    chk8("request ready", 8'h00, {7'h00, rd_req_ready});
    @(posedge clock);
    #1;
    fork
      acc_host_model_inst.req(1'h1, 7'h0c);
      begin
        repeat (5) @(posedge clock);
        #1;
        hold = 1'h0;
      end
    join
    acc_host_model_inst.drop_req();
    collect();
    for (int it = 0; it < 40; it++) begin
      fast_read = 1'($random(seed));
      repeat ($unsigned($random(seed)) % 3 + 1) put(3'($random(seed)));
      rd_seq(7'h00, 1);
      rd_seq(7'h0c, 1);
      chk8("irq flag", {7'h00, m_src[0]}, {7'h00, sample_ready_irq_flag});
      rd_seq(7'h00, fast_read ? 4 : 7);
      acc_host_model_inst.stop();
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- rtl/acc_axis_chan.sv
`timescale 1ns/10ps
`default_nettype none
module acc_axis_chan
  import acc_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic new_smp,
  input wire logic [W-1:0] smp_in,
  input wire logic hi_rd,
  output logic [W-1:0] sample_q,
  output logic [LO_W-1:0] lo_shadow_q,
  output logic ready_q,
  output logic overwrite_q,
  output logic ow_evt
);
  logic ready_d;
  logic overwrite_d;

  assign ow_evt = new_smp & ready_q;
  // a new sample in the clearing cycle keeps its flag set
  assign ready_d = new_smp | (ready_q & ~hi_rd); // [RULE_05]
  assign overwrite_d = ow_evt | (overwrite_q & ~hi_rd); // [RULE_04]

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sample_q <= SAMPLE_RST;
      lo_shadow_q <= LO_PAD;
      ready_q <= 1'b0; // [RULE_01]
      overwrite_q <= 1'b0; // [RULE_01]
    end else begin
      if (new_smp) begin
        sample_q <= smp_in; // [RULE_08]
      end
      // freeze the low nibble of the sample whose high byte went out
      if (hi_rd) begin
        lo_shadow_q <= sample_q[LO_W-1:0]; // [RULE_13]
      end
      ready_q <= ready_d;
      overwrite_q <= overwrite_d;
    end
  end

  ow_set_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_04]
    new_smp && ready_q |=> overwrite_q && ready_q)
    else $error("overwrite flag not set on unread sample");
  rdy_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_05]
    hi_rd && !new_smp |=> !ready_q && !overwrite_q)
    else $error("axis flags not cleared by high byte read");
  pair_hold_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_13]
    hi_rd |=> lo_shadow_q == $past(sample_q[LO_W-1:0]))
    else $error("low nibble not taken from read sample");
endmodule
`default_nettype wire

//--- rtl/acc_pkg.sv
package acc_pkg;

  localparam int ADDR_W = 7;
  localparam int SAMPLE_W = 12;
  localparam int AXES = 3;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int MODE_W = 2;
  localparam int FN_N = 5;

  // register offsets
  localparam logic [6:0] OFS_FLAGS = 7'h00;
  localparam logic [6:0] OFS_X_HI = 7'h01;
  localparam logic [6:0] OFS_X_LO = 7'h02;
  localparam logic [6:0] OFS_Y_HI = 7'h03;
  localparam logic [6:0] OFS_Y_LO = 7'h04;
  localparam logic [6:0] OFS_Z_HI = 7'h05;
  localparam logic [6:0] OFS_Z_LO = 7'h06;
  localparam logic [6:0] OFS_MODE = 7'h0b;
  localparam logic [6:0] OFS_IRQ = 7'h0c;
  localparam logic [6:0] AXIS_STRIDE = 7'h02;
  localparam logic [6:0] ADDR_STEP = 7'h01;
  localparam logic [6:0] ADDR_RST = 7'h00;

  // sample byte split: high byte is bits 11..4, low nibble bits 3..0
  localparam int HI_LSB = 4;
  localparam int LO_W = 4;
  localparam logic [3:0] LO_PAD = 4'h0;

  // reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] SAMPLE_RST = 12'h000;
  localparam logic [2:0] AXES_NONE = 3'h0;
  localparam logic [4:0] FN_NONE = 5'h00;

  // function interrupt indices
  localparam int FN_FFMT = 0;
  localparam int FN_PULSE = 1;
  localparam int FN_LNDPRT = 2;
  localparam int FN_TRANS = 3;
  localparam int FN_ASLP = 4;

  // reported operating modes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [5:0] MODE_PAD = 6'h00;

endpackage

//--- rtl/acc_sample_regs.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RULE_01] all status flags clear after reset
// [RULE_02] combined overwrite set when any axis overwritten
// [RULE_03] combined overwrite clears after all active highs read
// [RULE_04] axis overwrite set on unread replace, cleared by high
// [RULE_05] axis ready set on sample, cleared by high read
// [RULE_06] combined ready set on any enabled axis sample
// [RULE_07] combined ready clears after all enabled highs read
// [RULE_08] samples are 12-bit two's complement, current
// [RULE_09] high byte bits 11..4, low upper nibble 3..0
// [RULE_10] burst from status walks all six sample bytes
// [RULE_11] fast read skips low bytes in bursts
// [RULE_12] low byte valid only right after its high
// [RULE_13] high then low come from one sample
// [RULE_14] mode register: two mode bits, rest zero
// [RULE_15] host follows mode changes by reading mode register
// [RULE_16] source bit set on rise, cleared by source read
// [RULE_17] ready source clears on sample reads, not status
// [RULE_18] status byte: overwrites high nibble, readies low
// [RULE_19] auto-increment only in bursts, dropped on stop
// [RULE_20] reading status never changes any flag
module acc_sample_regs
  import acc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic smp_valid,
  input wire logic [AXES-1:0] smp_axis_en,
  input wire logic [SAMPLE_W-1:0] smp_x,
  input wire logic [SAMPLE_W-1:0] smp_y,
  input wire logic [SAMPLE_W-1:0] smp_z,
  input wire logic [AXES-1:0] axis_active,
  input wire logic fast_read,
  input wire logic [MODE_W-1:0] operating_mode,
  input wire logic [FN_N-1:0] func_irq,
  input wire logic [FN_N-2:0] func_src_rd,
  input wire logic drdy_irq_en,
  input wire logic rd_req_valid,
  output logic rd_req_ready,
  input wire logic rd_req_first,
  input wire logic [AW-1:0] rd_req_addr,
  input wire logic bus_stop,
  output logic rd_data_valid,
  input wire logic rd_data_ready,
  output logic [BYTE_W-1:0] rd_data,
  output logic sample_ready_irq_flag
);

  function automatic logic [6:0] hi_ofs(input int i);
    return OFS_X_HI + 7'(i) * AXIS_STRIDE;
  endfunction

  // Z low wraps to status so repeated bursts keep streaming sets
  function automatic logic [6:0] next_addr(input logic [6:0] a,
                                          input logic fast);
    if (a == OFS_Z_LO || (fast && a == OFS_Z_HI)) begin
      return OFS_FLAGS; // [RULE_10]
    end else if (fast && (a == OFS_X_HI || a == OFS_Y_HI)) begin
      return a + AXIS_STRIDE; // [RULE_11]
    end else begin
      return a + ADDR_STEP;
    end
  endfunction

  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic [AXES-1:0] last_hi_q;
  logic [AXES-1:0] last_hi_d;
  logic all_ow_q;
  logic all_ow_d;
  logic all_rdy_q;
  logic all_rdy_d;
  logic [FN_N-1:0] src_q;
  logic [FN_N-1:0] src_d;
  logic [FN_N-1:0] fn_prev_q;
  logic [FN_N-1:0] src_clr;
  logic drdy_src_q;
  logic drdy_src_d;
  logic drdy_lvl_q;
  logic drdy_lvl;

  logic take;
  logic [6:0] acc_addr;
  logic [SAMPLE_W-1:0] smp_arr [AXES];
  logic [SAMPLE_W-1:0] samp [AXES];
  logic [LO_W-1:0] lo_sh [AXES];
  logic [BYTE_W-1:0] axis_byte [AXES];
  logic [AXES-1:0] new_v;
  logic [AXES-1:0] rdy_v;
  logic [AXES-1:0] ow_v;
  logic [AXES-1:0] ow_evt;
  logic [AXES-1:0] hi_hit;
  logic [AXES-1:0] lo_hit;
  logic [AXES-1:0] hi_rd;
  logic [AXES-1:0] remaining;
  logic comb_clr;
  logic any_new;
  logic flags_hit;
  logic mode_hit;
  logic irq_hit;
  logic lo_ok;
  logic [BYTE_W-1:0] flags_byte;
  logic [BYTE_W-1:0] mode_byte;
  logic [BYTE_W-1:0] irq_byte;
  logic [BYTE_W-1:0] rd_byte;

  assign smp_arr[0] = smp_x;
  assign smp_arr[1] = smp_y;
  assign smp_arr[2] = smp_z;

  // a request only lands when the response buffer can hold its byte
  assign take = rd_req_valid & rd_req_ready;
  assign acc_addr = rd_req_first ? 7'(rd_req_addr) : addr_q; // [RULE_19]
  assign new_v = smp_axis_en & {AXES{smp_valid}};

  for (genvar i = 0; i < AXES; i++) begin : g_axis
    assign hi_hit[i] = (acc_addr == hi_ofs(i));
    assign lo_hit[i] = (acc_addr == hi_ofs(i) + ADDR_STEP);
    assign hi_rd[i] = take & hi_hit[i];
    assign axis_byte[i] =
      hi_hit[i] ? samp[i][SAMPLE_W-1:HI_LSB] : // [RULE_09]
      (lo_hit[i] && last_hi_q[i]) ? {lo_sh[i], LO_PAD} : // [RULE_12]
      BYTE_ZERO;

    acc_axis_chan #(
      .W(SAMPLE_W)
    ) u_chan (
      .clock(clock),
      .rst_b(rst_b),
      .new_smp(new_v[i]),
      .smp_in(smp_arr[i]),
      .hi_rd(hi_rd[i]),
      .sample_q(samp[i]),
      .lo_shadow_q(lo_sh[i]),
      .ready_q(rdy_v[i]),
      .overwrite_q(ow_v[i]),
      .ow_evt(ow_evt[i])
    );
  end

  // combined flags fall once no enabled axis still holds unread data
  assign remaining = rdy_v & ~hi_rd & axis_active;
  assign comb_clr = (|hi_rd) & (remaining == AXES_NONE); // [RULE_03]
  assign any_new = |(new_v & axis_active);
  assign all_rdy_d = any_new | (all_rdy_q & ~comb_clr); // [RULE_06] [RULE_07]
  assign all_ow_d = (|ow_evt) | (all_ow_q & ~comb_clr); // [RULE_02]

  assign flags_hit = (acc_addr == OFS_FLAGS);
  assign mode_hit = (acc_addr == OFS_MODE);
  assign irq_hit = (acc_addr == OFS_IRQ);
  assign lo_ok = |(lo_hit & last_hi_q);
  assign flags_byte = {all_ow_q, ow_v, all_rdy_q, rdy_v}; // [RULE_18]
  assign mode_byte = {MODE_PAD, operating_mode}; // [RULE_14]
  assign irq_byte = {src_q[FN_ASLP], 1'b0, src_q[FN_TRANS],
                     src_q[FN_LNDPRT], src_q[FN_PULSE], src_q[FN_FFMT],
                     1'b0, drdy_src_q};
  assign rd_byte = flags_hit ? flags_byte :
                   mode_hit ? mode_byte :
                   irq_hit ? irq_byte :
                   (axis_byte[0] | axis_byte[1] | axis_byte[2]);

  // sources latch on a rising level; reading a source register clears
  assign src_clr = {take & mode_hit, func_src_rd};
  assign src_d = (func_irq & ~fn_prev_q) | (src_q & ~src_clr); // [RULE_16]
  // status reads leave this bit alone; only the sample reads clear it
  assign drdy_lvl = (all_ow_q | all_rdy_q) & drdy_irq_en;
  assign drdy_src_d = (drdy_lvl & ~drdy_lvl_q) |
                      (drdy_src_q & ~comb_clr); // [RULE_17]
  assign sample_ready_irq_flag = drdy_src_q;

  // stop drops the stored address and any pending low-byte pairing
  assign addr_d = bus_stop ? ADDR_RST : // [RULE_19]
                  take ? next_addr(acc_addr, fast_read) : addr_q;
  assign last_hi_d = bus_stop ? AXES_NONE :
                     take ? hi_hit : last_hi_q; // [RULE_12]

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      addr_q <= ADDR_RST;
      last_hi_q <= AXES_NONE;
      all_ow_q <= 1'b0; // [RULE_01]
      all_rdy_q <= 1'b0; // [RULE_01]
      src_q <= FN_NONE;
      fn_prev_q <= FN_NONE;
      drdy_src_q <= 1'b0;
      drdy_lvl_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      last_hi_q <= last_hi_d;
      all_ow_q <= all_ow_d;
      all_rdy_q <= all_rdy_d;
      src_q <= src_d;
      fn_prev_q <= func_irq;
      drdy_src_q <= drdy_src_d;
      drdy_lvl_q <= drdy_lvl;
    end
  end

  // two entries let the serialiser stall a byte without losing the next
  acc_skid_buf #(
    .WIDTH(BYTE_W),
    .DEPTH(DEPTH)
  ) u_rsp_buf (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(rd_req_valid),
    .in_ready(rd_req_ready),
    .in_data(rd_byte),
    .out_valid(rd_data_valid),
    .out_ready(rd_data_ready),
    .out_data(rd_data)
  );

  sequence hi_then_lo_s;
    take && |hi_hit ##1 take && !rd_req_first;
  endsequence

  sequence status_read_s;
    take && flags_hit && !smp_valid;
  endsequence

  flags_reset_a: assert property (@(posedge clock) // [RULE_01]
    !rst_b |=> flags_byte == BYTE_ZERO && !drdy_src_q)
    else $error("status flags not cleared by reset");
  all_ow_set_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_02]
    |ow_evt |=> all_ow_q ##0 flags_byte[7])
    else $error("combined overwrite missed an axis overwrite");
  all_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_03]
    comb_clr && !smp_valid |=> !all_ow_q && !all_rdy_q)
    else $error("combined flags survive final high read");
  all_hold_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_07]
    all_rdy_q && !comb_clr |=> all_rdy_q)
    else $error("combined ready cleared too early");
  all_rdy_set_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_06]
    any_new |=> all_rdy_q)
    else $error("combined ready not set on new sample");
  fast_skip_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_11]
    take && fast_read && acc_addr == OFS_X_HI && !bus_stop
    |=> addr_q == OFS_Y_HI)
    else $error("fast read did not skip the low byte");
  burst_walk_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_10]
    take && !fast_read && acc_addr == OFS_X_HI && !bus_stop
    |=> addr_q == OFS_X_LO)
    else $error("burst did not step to the low byte");
  pair_lo_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_13]
    hi_then_lo_s |-> lo_ok == (acc_addr == $past(acc_addr) + ADDR_STEP))
    else $error("low byte pairing lost after high read");
  lo_random_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_12]
    take && |lo_hit && !lo_ok |-> rd_byte == BYTE_ZERO)
    else $error("unpaired low byte returned data");
  mode_read_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_14]
    take && mode_hit |-> rd_byte == {MODE_PAD, operating_mode})
    else $error("mode register content wrong");
  stop_drop_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_19]
    bus_stop |=> addr_q == ADDR_RST && last_hi_q == AXES_NONE)
    else $error("stop did not discard the burst address");
  status_keep_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_20]
    status_read_s |=> flags_byte == $past(flags_byte))
    else $error("status read changed a flag");
  drdy_keep_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_17]
    status_read_s and drdy_src_q |=> drdy_src_q)
    else $error("status read cleared ready source");
  src_rise_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE_16]
    func_irq[FN_PULSE] && !fn_prev_q[FN_PULSE] |=> src_q[FN_PULSE])
    else $error("source bit missed a rising interrupt");
  rsp_time_a: assert property (@(posedge clock) disable iff (!rst_b)
    take |=> rd_data_valid)
    else $error("read answer not buffered");
endmodule
`default_nettype wire

//--- rtl/acc_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none
module acc_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IW:0] FULL = (IW+1)'(DEPTH);
  localparam logic [IW:0] EMPTY = '0;
  localparam logic [IW-1:0] LAST = (IW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [IW-1:0] wr_q;
  logic [IW-1:0] rd_q;
  logic [IW:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [IW-1:0] wrap_inc(input logic [IW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != EMPTY);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= EMPTY;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= wrap_inc(wr_q);
      end
      if (pop) begin
        rd_q <= wrap_inc(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
